/* hw/ddr_cmd_cfg.svh */
// offsets, field positions, reset values and counts of the command decoder
`ifndef DDR_CMD_CFG_SVH
`define DDR_CMD_CFG_SVH
// register byte offsets on the control bus
`define OFS_CTRL     8'h00
`define OFS_STATUS   8'h04
`define OFS_MR0      8'h08
`define OFS_MR3      8'h14
`define MR_IDX_BASE  3'h2
// control register
`define CTRL_EN_BIT  0
`define CTRL_EN_RST  1'b1
// address bus flag positions
`define AP_BIT       10
`define BC_BIT       12
`define COL_W        10
// mode register fields
`define MR_BL_LO     0
`define MR_BT_BIT    3
`define MR_CL_LO     4
`define MR_AL_LO     3
`define BL_OTF       2'h1
`define BL_BC4       2'h2
`define CL_BASE      5'h04
// last clock index of a burst, two transfers per clock
`define LAST_FULL    2'h3
`define LAST_CHOP    2'h1
// bus answers
`define RESP_OKAY    2'b00
`define RESP_DECERR  2'b11
`endif

/* hw/ddr_cmd_pkg.sv */
// types shared by the command decoder and its helpers
package ddr_cmd_pkg;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR,
                            CMD_MRS} cmd_t;
  typedef enum logic [1:0] {B_IDLE, B_WAIT, B_DATA} burst_ph_t;
  typedef enum logic {AX_IDLE, AX_RESP} axi_ph_t;

  // command and address pins as sampled at the clock crossing
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  bank_select_lines;
    logic [14:0] multiplexed_address_bus;
  } ddr_cmd_bus_t;

  // one clock of burst column addresses, rising and falling transfer
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] bank;
    logic [9:0] col_rise;
    logic [9:0] col_fall;
  } beat_t;

  typedef struct packed {
    logic [7:0]       open;
    logic             suspended;
    logic             lowpower;
    logic [7:0]       cmd_cnt;
    logic [3:0][14:0] mr;
  } link_stat_t;

  typedef struct packed {
    logic             cke_r;
    logic             lowpower;
    logic [7:0]       open;
    logic [7:0][14:0] row;
    logic [3:0][14:0] mr;
    logic [7:0]       cmd_cnt;
    burst_ph_t        bph;
    logic [4:0]       lat;
    logic [1:0]       beat_i;
    logic [1:0]       last;
    logic             ap;
    logic             write;
    logic             interleave;
    logic [2:0]       bank;
    logic [9:0]       col;
    beat_t            out;
    logic             req;
    link_stat_t       snap;
  } link_st_t;

  typedef struct packed {
    axi_ph_t    wph;
    axi_ph_t    rph;
    logic       aw_got;
    logic       w_got;
    logic [7:0] waddr;
    logic       wbit;
    logic       wstb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic       ctrl_en;
    logic       ack;
    link_stat_t stat;
  } sys_st_t;

  typedef struct packed {
    logic meta;
    logic q;
  } sync_st_t;
endpackage

/* hw/sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sync2
  import ddr_cmd_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic d_i,
  output logic      q_o
);
  sync_st_t st_r;
  sync_st_t st_nxt;

  // meta feeds only the second stage
  always_comb begin
    st_nxt.meta = d_i;
    st_nxt.q    = st_r.meta;
  end

  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
  end

  assign q_o = st_r.q;
endmodule

/* hw/burst_order.sv */
// low column bits of one burst transfer, sequential or interleaved
`timescale 1ns/1ps
module burst_order
  import ddr_cmd_pkg::*;
(
  input  wire logic [2:0] start_i,
  input  wire logic [2:0] beat_i,
  input  wire logic       interleave_i,
  output logic [2:0]      col_o
);
  logic [1:0] low_sum;

  // sequential wraps inside the nibble, bit 2 flips after four transfers
  always_comb begin
    low_sum = start_i[1:0] + beat_i[1:0];
    if (interleave_i) begin
      col_o = start_i ^ beat_i;
    end else begin
      col_o = {start_i[2] ^ beat_i[2], low_sum};
    end
  end
endmodule

/* hw/sdram_command_address_decode.sv */
// command and address decode of an eight-bank ddr dram, axi-lite status
//
// Overview of operation
// - capture inputs on true clock rising only
// - burst columns for both transfer edges of a clock
// - gate low freezes state from next cycle
// - gate fall with idle banks enters low power
// - commands act only on selected bank, except precharge all
// - activate stores full fifteen-bit row
// - start column from lowest ten address bits
// - mode set loads opcode into selected register
// - auto-precharge flag closes bank after burst
// - precharge flag low one bank, high all
// - burst chop flag low shortens burst
// - burst length four or eight, both orders
// - added latency zero, cl-1 or cl-2
// - chip select high masks every command
// - strobes decode activate, precharge, read, write
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ddr_cmd_cfg.svh"
module sdram_command_address_decode
  import ddr_cmd_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        link_clk_i,
  input  wire ddr_cmd_bus_t cmd_i,
  output beat_t            beat_o
);
  // ==========================================================
  // helpers
  function automatic logic [7:0] bank_mask(input logic [2:0] b);
    bank_mask = 8'h01 << b;
  endfunction

  function automatic logic [4:0] read_lat(input logic [14:0] m0,
                                          input logic [14:0] m1);
    logic [4:0] cl;
    cl = `CL_BASE + {2'h0, m0[`MR_CL_LO +: 3]};
    case (m1[`MR_AL_LO +: 2])
      2'h1:    read_lat = cl + cl - 5'h01;
      2'h2:    read_lat = cl + cl - 5'h02;
      default: read_lat = cl;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_MR3);
  endfunction

  // ==========================================================
  // crossings
  link_st_t lst;
  link_st_t ln;
  sys_st_t  sst;
  sys_st_t  sn;
  logic     lrst;
  logic     en_s;
  logic     ack_s;
  logic     req_s;

  // reset and enable reach the link side as levels
  sync2 u_rst_sync (.clk_i(link_clk_i), .d_i(reset_i),     .q_o(lrst));
  sync2 u_en_sync  (.clk_i(link_clk_i), .d_i(sst.ctrl_en), .q_o(en_s));
  sync2 u_ack_sync (.clk_i(link_clk_i), .d_i(sst.ack),     .q_o(ack_s));
  sync2 u_req_sync (.clk_i(sys_clk_i),  .d_i(lst.req),     .q_o(req_s));

  // ==========================================================
  // link side: decode at the true clock rising edge
  cmd_t       cmd;
  logic       act_t;
  logic       pre_t;
  logic       rdwr_t;
  logic       mrs_t;
  logic       chop;
  logic [2:0] ord_rise;
  logic [2:0] ord_fall;
  logic [2:0] ba;
  logic [14:0] addr;

  assign ba   = cmd_i.bank_select_lines;
  assign addr = cmd_i.multiplexed_address_bus;

  burst_order u_ord_rise (
    .start_i      (lst.col[2:0]),
    .beat_i       ({lst.beat_i, 1'b0}),
    .interleave_i (lst.interleave),
    .col_o        (ord_rise)
  );
  burst_order u_ord_fall (
    .start_i      (lst.col[2:0]),
    .beat_i       ({lst.beat_i, 1'b1}),
    .interleave_i (lst.interleave),
    .col_o        (ord_fall)
  );

  // strobe decode; only a running internal clock takes commands
  always_comb begin
    cmd = CMD_NOP;
    if (en_s && lst.cke_r && !cmd_i.cs_n) begin
      case ({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n})
        3'b011:  cmd = CMD_ACT;
        3'b010:  cmd = CMD_PRE;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b000:  cmd = CMD_MRS;
        default: cmd = CMD_NOP;
      endcase
    end
    act_t  = (cmd == CMD_ACT);
    pre_t  = (cmd == CMD_PRE);
    rdwr_t = (cmd == CMD_RD) || (cmd == CMD_WR);
    mrs_t  = (cmd == CMD_MRS);
    if (lst.mr[0][`MR_BL_LO +: 2] == `BL_OTF) begin
      chop = !addr[`BC_BIT];
    end else begin
      chop = (lst.mr[0][`MR_BL_LO +: 2] == `BL_BC4);
    end
  end

  // link next state; a stopped internal clock holds all but the gate, the low power flag and the snapshot
  always_comb begin
    ln = lst;
    ln.cke_r = cmd_i.cke;
    // entry needs idle banks, otherwise it is only a clock stop
    if (cmd_i.cke) begin
      ln.lowpower = 1'b0;
    end else if (lst.cke_r && lst.open == 8'h00 && lst.bph == B_IDLE) begin
      ln.lowpower = 1'b1;
    end
    if (lst.cke_r) begin
      ln.out.valid = 1'b0;
      case (lst.bph)
        B_WAIT: begin
          if (lst.lat == 5'h00) begin
            ln.bph = B_DATA;
          end else begin
            ln.lat = lst.lat - 5'h01;
          end
        end
        B_DATA: begin
          ln.out.valid    = 1'b1;
          ln.out.write    = lst.write;
          ln.out.bank     = lst.bank;
          ln.out.col_rise = {lst.col[9:3], ord_rise};
          ln.out.col_fall = {lst.col[9:3], ord_fall};
          if (lst.beat_i == lst.last) begin
            ln.bph = B_IDLE;
            if (lst.ap) begin
              ln.open = lst.open & ~bank_mask(lst.bank);
            end
          end else begin
            ln.beat_i = lst.beat_i + 2'h1;
          end
        end
        default: ln.bph = B_IDLE;
      endcase
      if (cmd != CMD_NOP) begin
        ln.cmd_cnt = lst.cmd_cnt + 8'h01;
      end
      if (act_t) begin
        ln.open    = ln.open | bank_mask(ba);
        ln.row[ba] = addr;
      end
      if (pre_t) begin
        if (addr[`AP_BIT]) begin
          ln.open = 8'h00;
        end else begin
          ln.open = ln.open & ~bank_mask(ba);
        end
      end
      // a new column command supersedes a burst still in flight
      if (rdwr_t) begin
        ln.bph        = B_WAIT;
        ln.lat        = read_lat(lst.mr[0], lst.mr[1]) - 5'h02;
        ln.beat_i     = 2'h0;
        ln.last       = chop ? `LAST_CHOP : `LAST_FULL;
        ln.ap         = addr[`AP_BIT];
        ln.write      = (cmd == CMD_WR);
        ln.bank       = ba;
        ln.col        = addr[`COL_W-1:0];
        ln.interleave = lst.mr[0][`MR_BT_BIT];
      end
      if (mrs_t) begin
        ln.mr[ba[1:0]] = addr;
      end
    end
    // snapshot reloads only after the other side has acknowledged
    if (lst.req == ack_s) begin
      ln.snap.open      = lst.open;
      ln.snap.suspended = !lst.cke_r;
      ln.snap.lowpower  = lst.lowpower;
      ln.snap.cmd_cnt   = lst.cmd_cnt;
      ln.snap.mr        = lst.mr;
      ln.req            = !lst.req;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      lst <= '0;
    end else begin
      lst <= ln;
    end
  end

  assign beat_o = lst.out;

  // ==========================================================
  // system side: axi-lite slave
  logic [2:0] ridx;
  assign ridx = s_axi_araddr_i[4:2] - `MR_IDX_BASE;

  always_comb begin
    sn = sst;
    // snap is stable while the request stays unacknowledged
    if (req_s != sst.ack) begin
      sn.stat = lst.snap;
      sn.ack  = req_s;
    end
    case (sst.wph)
      AX_IDLE: begin
        if (s_axi_awvalid_i && !sst.aw_got) begin
          sn.aw_got = 1'b1;
          sn.waddr  = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !sst.w_got) begin
          sn.w_got = 1'b1;
          sn.wbit  = s_axi_wdata_i[`CTRL_EN_BIT];
          sn.wstb  = s_axi_wstrb_i[0];
        end
        if (sn.aw_got && sn.w_got) begin
          sn.wph = AX_RESP;
          if (sn.waddr == `OFS_CTRL) begin
            sn.bresp = `RESP_OKAY;
            if (sn.wstb) begin
              sn.ctrl_en = sn.wbit;
            end
          end else if (mapped(sn.waddr)) begin
            sn.bresp = `RESP_OKAY;
          end else begin
            sn.bresp = `RESP_DECERR;
          end
        end
      end
      default: begin
        if (s_axi_bready_i) begin
          sn.wph    = AX_IDLE;
          sn.aw_got = 1'b0;
          sn.w_got  = 1'b0;
        end
      end
    endcase
    case (sst.rph)
      AX_IDLE: begin
        if (s_axi_arvalid_i) begin
          sn.rph   = AX_RESP;
          sn.rresp = `RESP_OKAY;
          if (s_axi_araddr_i == `OFS_CTRL) begin
            sn.rdata = {31'h0, sst.ctrl_en};
          end else if (s_axi_araddr_i == `OFS_STATUS) begin
            sn.rdata = {8'h00, sst.stat.cmd_cnt, 6'h00, sst.stat.lowpower,
                        sst.stat.suspended, sst.stat.open};
          end else if (mapped(s_axi_araddr_i)) begin
            sn.rdata = {17'h0, sst.stat.mr[ridx[1:0]]};
          end else begin
            sn.rdata = 32'h0000_0000;
            sn.rresp = `RESP_DECERR;
          end
        end
      end
      default: begin
        if (s_axi_rready_i) begin
          sn.rph = AX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sst         <= '0;
      sst.ctrl_en <= `CTRL_EN_RST;
    end else begin
      sst <= sn;
    end
  end

  // handshake outputs straight from phase, data from flops
  assign s_axi_awready_o = (sst.wph == AX_IDLE) && !sst.aw_got;
  assign s_axi_wready_o  = (sst.wph == AX_IDLE) && !sst.w_got;
  assign s_axi_bvalid_o  = (sst.wph == AX_RESP);
  assign s_axi_bresp_o   = sst.bresp;
  assign s_axi_arready_o = (sst.rph == AX_IDLE);
  assign s_axi_rvalid_o  = (sst.rph == AX_RESP);
  assign s_axi_rdata_o   = sst.rdata;
  assign s_axi_rresp_o   = sst.rresp;

  // ==========================================================
  // checks
  property p_act_open;
    @(posedge link_clk_i) disable iff (lrst)
    act_t |=> lst.open[$past(ba)] && lst.row[$past(ba)] == $past(addr);
  endproperty
  a_act_open: assert property (p_act_open)
    else $error("activate did not open the row");

  property p_pre_all;
    @(posedge link_clk_i) disable iff (lrst)
    pre_t && addr[`AP_BIT] |=> lst.open == 8'h00;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");

  property p_pre_one;
    @(posedge link_clk_i) disable iff (lrst)
    pre_t && !addr[`AP_BIT] && lst.bph != B_DATA |=>
      lst.open == ($past(lst.open) & ~bank_mask($past(ba)));
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("single precharge touched another bank");

  property p_freeze;
    @(posedge link_clk_i) disable iff (lrst)
    !lst.cke_r |=> $stable(beat_o) && $stable(lst.open);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock gate low");

  property p_mrs;
    @(posedge link_clk_i) disable iff (lrst)
    mrs_t |=> lst.mr[$past(ba[1:0])] == $past(addr);
  endproperty
  a_mrs: assert property (p_mrs)
    else $error("mode opcode not loaded");

  property p_cs_mask;
    @(posedge link_clk_i) disable iff (lrst)
    cmd_i.cs_n && lst.bph != B_DATA |=>
      $stable(lst.open) && $stable(lst.cmd_cnt);
  endproperty
  a_cs_mask: assert property (p_cs_mask)
    else $error("command taken with chip select high");

  property p_ap_close;
    @(posedge link_clk_i) disable iff (lrst)
    lst.cke_r && lst.bph == B_DATA && lst.beat_i == lst.last && lst.ap
      && !act_t |=> !lst.open[$past(lst.bank)];
  endproperty
  a_ap_close: assert property (p_ap_close)
    else $error("auto-precharge did not close bank");

  property p_lowpower;
    @(posedge link_clk_i) disable iff (lrst)
    lst.cke_r && !cmd_i.cke && lst.open == 8'h00 && lst.bph == B_IDLE
      |=> lst.lowpower ##1 (lst.lowpower || $past(cmd_i.cke));
  endproperty
  a_lowpower: assert property (p_lowpower)
    else $error("idle gate fall missed low power");

  property p_chop_beats;
    @(posedge link_clk_i) disable iff (lrst)
    rdwr_t && chop |=> lst.last == `LAST_CHOP && lst.bph == B_WAIT;
  endproperty
  a_chop_beats: assert property (p_chop_beats)
    else $error("chopped burst length wrong");
endmodule

/* sim/ddr_ctrl_model.sv */
// memory controller model driving the command and address pins
`timescale 1ns/1ps
module ddr_ctrl_model
  import ddr_cmd_pkg::*;
(
  input  wire logic    link_clk_i,
  output ddr_cmd_bus_t cmd_o
);
  // idle pins: deselected, clock gate on
  initial begin
    cmd_o = {1'b1, 1'b1, 3'b111, 3'h0, 15'h0000};
  end

  // one command for one link cycle; released bank and address pins carry the inverse
  // of the last value so stale address bits never look valid
  task automatic issue(input logic [2:0]  rcw,
                       input logic [2:0]  ba,
                       input logic [14:0] a,
                       input logic        cs_n);
    @(posedge link_clk_i);
    cmd_o.cs_n <= cs_n;
    {cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} <= rcw;
    cmd_o.bank_select_lines <= ba;
    cmd_o.multiplexed_address_bus <= a;
    @(posedge link_clk_i);
    cmd_o.cs_n <= 1'b1;
    {cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} <= 3'b111;
    cmd_o.bank_select_lines <= ~ba;
    cmd_o.multiplexed_address_bus <= ~a;
  endtask

  // clock gate; a fall counts as low power entry only with banks idle
  task automatic set_cke(input logic v);
    @(posedge link_clk_i);
    cmd_o.cke <= v;
  endtask
endmodule

/* sim/sdram_command_address_decode_tb.sv */
// self-checking bench: register bus reads and link command sequences
`timescale 1ns/1ps
`include "ddr_cmd_cfg.svh"
module sdram_command_address_decode_tb
  import ddr_cmd_pkg::*;
;
  localparam logic [2:0] C_ACT = 3'b011;
  localparam logic [2:0] C_PRE = 3'b010;
  localparam logic [2:0] C_RD  = 3'b101;
  localparam logic [2:0] C_WR  = 3'b100;
  localparam logic [2:0] C_MRS = 3'b000;
  localparam logic [2:0] C_REF = 3'b001;
  // ======================================================
  // signals
  logic         clk, rst, lclk;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, rv;
  logic         awvalid, wvalid, bready, arvalid, rready, en;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp, rr;
  logic [3:0]   strb;
  ddr_cmd_bus_t cmd;
  beat_t        beat, frz;
  int           errors, checks_done, cnt, lat0, n, k;

  // clocks of unrelated phase
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end

  sdram_command_address_decode u_sdram_command_address_decode (
    .sys_clk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .link_clk_i(lclk),
    .cmd_i(cmd), .beat_o(beat));

  ddr_ctrl_model u_ddr_ctrl_model (.link_clk_i(lclk), .cmd_o(cmd));

  // ======================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic tmo(input int t);
    if (t >= 60) begin
      errors++;
      $display("[ERR] wait exp done got timeout");
      finish_test();
    end
  endtask

  // ======================================================
  // one bus transfer; each valid drops at the edge that takes it
  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= {3{wr}};
    {arvalid, rready} <= {2{!wr}};
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while ((awvalid || wvalid || arvalid) && k < 60);
    while ((wr ? bvalid : rvalid) !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    tmo(k);
    rr = wr ? bresp : rresp;
    rv = rdata;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  // status snapshot lags the link side, so let it settle first
  task automatic st(input logic [15:0] lo);
    repeat (16) @(posedge clk);
    axi(1'b0, `OFS_STATUS, 32'h0);
    chk("status", {8'h00, cnt[7:0], lo}, rv);
  endtask
  // command through the partner, tracking the recognised count
  task automatic cmd_go(input logic [2:0] rcw, input logic [2:0] ba,
                        input logic [14:0] a, input logic cs_n);
    u_ddr_ctrl_model.issue(rcw, ba, a, cs_n);
    if (!cs_n && en && rcw inside {C_ACT, C_PRE, C_RD, C_WR, C_MRS})
      cnt++;
  endtask
  // column access and check of every transfer of its burst
  task automatic burst(input logic [2:0] rcw, input logic [2:0] ba,
                       input logic [14:0] a, input int nb,
                       input logic il, output int lat);
    logic [2:0] t;
    logic [9:0] g;
    int         i;
    cmd_go(rcw, ba, a, 1'b0);
    lat = 0;
    while (beat.valid !== 1'b1 && lat < 60) begin
      @(negedge lclk);
      lat++;
    end
    tmo(lat);
    for (i = 0; i < 2 * nb; i++) begin
      t = il ? a[2:0] ^ i[2:0] : {a[2] ^ i[2], a[1:0] + i[1:0]};
      g = i[0] ? beat.col_fall : beat.col_rise;
      chk("col", {a[9:3], t}, g);
      chk("bank", ba, beat.bank);
      chk("write", rcw == C_WR, beat.write);
      if (i[0]) @(negedge lclk);
    end
    chk("burst_end", 0, beat.valid);
  endtask

  // ======================================================
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {errors, checks_done, cnt} = '0;
    en = 1'b1;
    strb = 4'hf;
    rst = 1'b1;
    // link side needs three of its own edges inside reset
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // every channel is open while nothing is pending
    chk("readies", 3'h7, {awready, wready, arready});
    axi(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", 1, rv);
    // a write whose low strobe is clear leaves the enable bit alone
    strb <= 4'he;
    axi(1'b1, `OFS_CTRL, 32'h0);
    strb <= 4'hf;
    axi(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl_strb", 1, rv);
    axi(1'b0, 8'h09, 32'h0);
    chk("rresp", `RESP_DECERR, rr);
    chk("rdata", 0, rv);
    axi(1'b1, 8'h40, 32'h1);
    chk("bresp", `RESP_DECERR, rr);
    axi(1'b1, `OFS_STATUS, 32'hff);
    chk("bresp_ro", `RESP_OKAY, rr);
    st(16'h0000);
    $display("test reset done");
    // mode registers, then two rows opened
    cmd_go(C_MRS, 3'h0, 15'h0000, 1'b0);
    cmd_go(C_MRS, 3'h2, 15'h0a5a, 1'b0);
    cmd_go(C_MRS, 3'h3, 15'h1234, 1'b0);
    repeat (16) @(posedge clk);
    axi(1'b0, `OFS_MR3, 32'h0);
    chk("mr3", 32'h1234, rv);
    axi(1'b0, `OFS_MR3 - 8'h04, 32'h0);
    chk("mr2", 32'h0a5a, rv);
    cmd_go(C_ACT, 3'h3, 15'h7abc, 1'b0);
    cmd_go(C_ACT, 3'h5, 15'h0001, 1'b0);
    st(16'h0028);
    $display("test mode and activate done");
    // full sequential read; high address bits must not reach column
    burst(C_RD, 3'h3, 15'h6ac9, 4, 1'b0, lat0);
    // valid first shows cl edges after the sampling edge, one negedge on
    chk("rd_lat", `CL_BASE + 32'h1, lat0);
    st(16'h0028);
    // interleaved, on the fly chop then full
    cmd_go(C_MRS, 3'h0, 15'h0009, 1'b0);
    burst(C_RD, 3'h3, 15'h0015, 2, 1'b1, n);
    burst(C_RD, 3'h3, 15'h1016, 4, 1'b1, n);
    chk("otf_lat", lat0, n);
    // added latency zero, cl-1, cl-2 with cl of four
    for (int j = 1; j < 4; j++) begin
      cmd_go(C_MRS, 3'h1, 15'(j << 3), 1'b0);
      burst(C_RD, 3'h5, 15'h1003, 4, 1'b1, n);
      chk("al_lat", lat0 + (j == 1 ? 3 : j == 2 ? 2 : 0), n);
    end
    cmd_go(C_MRS, 3'h1, 15'h0000, 1'b0);
    cmd_go(C_MRS, 3'h0, 15'h0010, 1'b0);
    burst(C_RD, 3'h5, 15'h0007, 4, 1'b0, n);
    chk("cl_lat", lat0 + 1, n);
    // fixed chop write with auto precharge closes its bank
    cmd_go(C_MRS, 3'h0, 15'h0002, 1'b0);
    burst(C_WR, 3'h5, 15'h0403, 2, 1'b0, n);
    st(16'h0008);
    $display("test bursts done");
    // deselected, refresh and disabled decoder change nothing
    cmd_go(C_ACT, 3'h0, 15'h0000, 1'b1);
    cmd_go(C_REF, 3'h0, 15'h0000, 1'b0);
    axi(1'b1, `OFS_CTRL, 32'h0);
    en = 1'b0;
    repeat (8) @(posedge clk);
    cmd_go(C_ACT, 3'h1, 15'h0000, 1'b0);
    axi(1'b1, `OFS_CTRL, 32'h1);
    en = 1'b1;
    st(16'h0008);
    // clock gate low in mid burst freezes the transfer outputs
    cmd_go(C_MRS, 3'h0, 15'h0000, 1'b0);
    cmd_go(C_RD, 3'h3, 15'h0000, 1'b0);
    n = 0;
    while (beat.valid !== 1'b1 && n < 60) begin
      @(negedge lclk);
      n++;
    end
    tmo(n);
    u_ddr_ctrl_model.set_cke(1'b0);
    repeat (3) @(negedge lclk);
    frz = beat;
    chk("frz_valid", 1, frz.valid);
    repeat (3) begin
      @(negedge lclk);
      chk("frozen", frz, beat);
    end
    u_ddr_ctrl_model.set_cke(1'b1);
    repeat (8) @(negedge lclk);
    // one bank precharge, then every bank
    cmd_go(C_ACT, 3'h6, 15'h0100, 1'b0);
    cmd_go(C_PRE, 3'h6, 15'h0000, 1'b0);
    st(16'h0008);
    cmd_go(C_ACT, 3'h6, 15'h0100, 1'b0);
    cmd_go(C_PRE, 3'h0, 15'h0400, 1'b0);
    st(16'h0000);
    // gate low with every bank idle enters low power
    u_ddr_ctrl_model.set_cke(1'b0);
    st(16'h0300);
    u_ddr_ctrl_model.set_cke(1'b1);
    st(16'h0000);
    $display("test gate and precharge done");
    finish_test();
  end
endmodule
